/* File: logic/psr_pkg.sv */
// Shared constants for the serial register port
package psr_pkg;
   localparam int             FRAME_BITS  = 32;
   localparam int             ADDR_BITS   = 6;
   localparam int             DATA_BITS   = 24;
   localparam int             REG_COUNT   = 64;
   localparam int             CNT_BITS    = 6;
   // Bit count after which the address is complete (flag + 6 address)
   localparam logic [5:0]     CNT_ADDR    = 6'h07;
   // Bit count after the null bit, data phase starts
   localparam logic [5:0]     CNT_NULL    = 6'h08;
   localparam logic [5:0]     CNT_LAST    = 6'h20;
   localparam logic [23:0]    REG_RESET   = 24'h00_0000;
   // Read-only register: index and fixed value
   localparam logic [5:0]     RO_ADDR     = 6'h07;
   localparam logic [23:0]    RO_VALUE    = 24'h00_0000;
   localparam logic [5:0]     COR_ADDR    = 6'h02;
   localparam logic [5:0]     W1C_ADDR    = 6'h00;
   localparam logic [23:0]    FULL_MASK   = 24'hFF_FFFF;
   // Cold-start mode codes
   localparam logic           MODE_SPI    = 1'b0;
   localparam logic           MODE_I2C    = 1'b1;
endpackage

/* File: logic/psr_sync.sv */
// Three-stage synchroniser with second/third agreement filter
module psr_sync
(
   // Clock and reset
   input  wire logic i_clk,
   input  wire logic i_arst_n,
   // Data
   input  wire logic i_async,
   output logic      o_level
);
   logic [2:0] sh_reg;
   logic [2:0] sh_next;
   logic       lvl_reg;
   logic       lvl_next;

   // ==========================================================
   // Shift and filter
   always_comb
   begin
      sh_next  = {sh_reg[1:0], i_async};
      lvl_next = lvl_reg;
      if (sh_reg[1] == sh_reg[2])   // Stage 0 is read only by stage 1
      begin
         lvl_next = sh_reg[2];
      end
   end

   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         sh_reg  <= 3'h0;
         lvl_reg <= 1'b0;
      end
      else
      begin
         sh_reg  <= sh_next;
         lvl_reg <= lvl_next;
      end
   end

   assign o_level = lvl_reg;
endmodule

/* File: logic/psr_port.sv */
// Serial register port: frame engine on link clock, cold-start mode latch
// Notes on behaviour
// R1: Cold start samples select once, latching mode
// R2: Weak pull-down request on select; code drops it once I2C mode is latched
// R3: Frame: flag, six address, null, 24 data
// R4: Six-bit address picks one of 64
// R5: Header bits sampled on rising clock, MSB first
// R6: Host sends zero to read, one to write
// R7: Data shifted out on falling edges, MSB first
// R8: Read frames leave register unchanged
// R9: Write commits on 32nd falling edge
// R10: Write frames also shift out old contents
// R11: Host holds select high whole frame
// R12: Select drop before 32nd falling discards frame
// R13: Host toggles select low between frames
// R14: Data output off while select low
// R15: Bits follow their access types
// R16: Host writes zeros to unused bits
// R17: Readback returns zeros in address and unused
// R18: I2C mode: serial input gives address LSB
// R19: Counter and shifter cleared while select low
module psr_port
#(
   parameter logic [23:0] UNUSED_MASK = 24'hFF_FFFF
)
(
   // System clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_arst_n,
   // Link pins
   input  wire logic        i_sclk,
   input  wire logic        i_cs,
   input  wire logic        i_mosi,
   output logic             o_miso,
   output logic             o_miso_oe_n,
   output logic             o_cs_pulldown,
   // Cold start and mode
   input  wire logic        i_cold_start,
   output logic             o_i2c_mode,
   output logic             o_i2c_addr_lsb,
   // Register side (system clock)
   output logic             o_wr_stb,
   output logic [5:0]       o_wr_addr,
   output logic [23:0]      o_wr_data,
   input  wire logic [23:0] i_hw_status,
   input  wire logic [23:0] i_hw_set
);
   // ==========================================================
   // Register storage (system clock)
   logic [23:0] mem_reg [64];
   logic [23:0] mem_next [64];

   // ==========================================================
   // Link domain: rising-edge input shifter
   logic [5:0]  cnt_reg;
   logic [5:0]  cnt_next;
   logic [31:0] sin_reg;
   logic [31:0] sin_next;
   logic [5:0]  hdr_addr;
   logic        mode_reg;

   // After eight bits the null bit sits below the address field
   assign hdr_addr = sin_reg[6:1];

   // Count and capture header, then data
   always_comb
   begin
      cnt_next = cnt_reg;
      sin_next = sin_reg;
      if (cnt_reg != psr_pkg::CNT_LAST)
      begin
         cnt_next = cnt_reg + 6'h01;
         sin_next = {sin_reg[30:0], i_mosi};      // R3 R5
      end
   end

   // Reset by select low so each frame counts from the flag bit
   always_ff @(posedge i_sclk or negedge i_cs)
   begin
      if (!i_cs)
      begin
         cnt_reg <= 6'h00;                        // R19
         sin_reg <= 32'h0000_0000;
      end
      else
      begin
         cnt_reg <= cnt_next;
         sin_reg <= sin_next;
      end
   end

   // ==========================================================
   // Link domain: falling-edge output and commit
   logic [23:0] sout_reg;
   logic [23:0] sout_next;
   logic        out_reg;
   logic        out_next;
   logic        tog_reg;
   logic        tog_next;
   logic [5:0]  cadr_reg;
   logic [5:0]  cadr_next;
   logic [23:0] cdat_reg;
   logic [23:0] cdat_next;
   logic [23:0] rd_word;

   // Read path crosses asynchronously; the null bit gives decode time
   // and the register is stable apart from rare hardware updates.
   assign rd_word = mem_reg[hdr_addr] & UNUSED_MASK;   // R4 R17

   always_comb
   begin
      sout_next = sout_reg;
      out_next  = out_reg;
      tog_next  = tog_reg;
      cadr_next = cadr_reg;
      cdat_next = cdat_reg;
      if (cnt_reg == psr_pkg::CNT_NULL)
      begin
         // Same output for read and write frames
         out_next  = rd_word[23];                 // R7 R10
         sout_next = {rd_word[22:0], 1'b0};
      end
      else if (cnt_reg > psr_pkg::CNT_NULL)
      begin
         out_next  = sout_reg[23];                // R7
         sout_next = {sout_reg[22:0], 1'b0};
      end
      else
      begin
         out_next  = 1'b0;                        // R17
      end
      if (cnt_reg == psr_pkg::CNT_LAST && sin_reg[31])  // R8 R12
      begin
         cadr_next = sin_reg[30:25];
         cdat_next = sin_reg[23:0] & UNUSED_MASK;
         tog_next  = ~tog_reg;                    // R9
      end
   end

   // Toggle and payload are cleared only by system reset; both survive select
   always_ff @(negedge i_sclk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         tog_reg  <= 1'b0;
         cadr_reg <= 6'h00;
         cdat_reg <= 24'h00_0000;
      end
      else
      begin
         tog_reg  <= tog_next;
         cadr_reg <= cadr_next;
         cdat_reg <= cdat_next;
      end
   end

   always_ff @(negedge i_sclk or negedge i_cs)
   begin
      if (!i_cs)
      begin
         sout_reg <= 24'h00_0000;                 // R19
         out_reg  <= 1'b0;
      end
      else
      begin
         sout_reg <= sout_next;
         out_reg  <= out_next;
      end
   end

   // Pad driver; output enable active low
   assign o_miso      = out_reg;
   assign o_miso_oe_n = ~(i_cs & ~mode_reg);      // R14

   // ==========================================================
   // System domain: cold-start latch and mode outputs
   logic cs_lvl;
   logic mosi_lvl;
   logic tog_lvl;
   logic mode_next;
   logic done_reg;
   logic done_next;
   logic a0_reg;
   logic a0_next;

   psr_sync u_cs_sync
   (
      .i_clk    (i_clk),
      .i_arst_n (i_arst_n),
      .i_async  (i_cs),
      .o_level  (cs_lvl)
   );

   psr_sync u_mosi_sync
   (
      .i_clk    (i_clk),
      .i_arst_n (i_arst_n),
      .i_async  (i_mosi),
      .o_level  (mosi_lvl)
   );

   psr_sync u_tog_sync
   (
      .i_clk    (i_clk),
      .i_arst_n (i_arst_n),
      .i_async  (tog_reg),
      .o_level  (tog_lvl)
   );

   // Mode caught once on the first cold-start cycle after reset
   always_comb
   begin
      mode_next = mode_reg;
      done_next = done_reg;
      a0_next   = a0_reg;
      if (i_cold_start && !done_reg)
      begin
         mode_next = cs_lvl ? psr_pkg::MODE_I2C : psr_pkg::MODE_SPI; // R1
         done_next = 1'b1;
      end
      if (mode_reg == psr_pkg::MODE_I2C)
      begin
         a0_next = mosi_lvl;                      // R18
      end
   end

   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         mode_reg <= psr_pkg::MODE_SPI;
         done_reg <= 1'b0;
         a0_reg   <= 1'b0;
      end
      else
      begin
         mode_reg <= mode_next;
         done_reg <= done_next;
         a0_reg   <= a0_next;
      end
   end

   // ==========================================================
   // System domain: commit and register behaviour
   logic        tseen_reg;
   logic        tseen_next;
   logic        stb_reg;
   logic        stb_next;
   logic [5:0]  wa_reg;
   logic [5:0]  wa_next;
   logic [23:0] wd_reg;
   logic [23:0] wd_next;
   logic        pd_reg;
   logic        pd_next;

   always_comb
   begin
      tseen_next = tog_lvl;
      stb_next   = 1'b0;
      wa_next    = wa_reg;
      wd_next    = wd_reg;
      pd_next    = (mode_reg == psr_pkg::MODE_SPI);   // R2
      for (int i = 0; i < psr_pkg::REG_COUNT; i++)
      begin
         mem_next[i] = mem_reg[i];
      end
      // Hardware events set status bits; set beats clear
      mem_next[psr_pkg::W1C_ADDR] = mem_reg[psr_pkg::W1C_ADDR] | i_hw_set;
      // Payload is stable: it changed on the same edge as the toggle, which the synchroniser delays
      if (tog_lvl != tseen_reg)
      begin
         stb_next = 1'b1;
         wa_next  = cadr_reg;
         wd_next  = cdat_reg;
         unique case (1'b1)
            (cadr_reg == psr_pkg::W1C_ADDR):
            begin
               mem_next[cadr_reg] = (mem_reg[cadr_reg] & ~cdat_reg)
                                    | i_hw_set;  // R15
            end
            (cadr_reg == psr_pkg::RO_ADDR):
            begin
               mem_next[cadr_reg] = mem_reg[cadr_reg];   // R15
            end
            (cadr_reg == psr_pkg::COR_ADDR):
            begin
               mem_next[cadr_reg] = mem_reg[cadr_reg];   // R15
            end
            default:
            begin
               mem_next[cadr_reg] = cdat_reg;     // R9
            end
         endcase
      end
      mem_next[psr_pkg::RO_ADDR]  = psr_pkg::RO_VALUE;
      mem_next[psr_pkg::COR_ADDR] = i_hw_status;
   end

   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         tseen_reg <= 1'b0;
         stb_reg   <= 1'b0;
         wa_reg    <= 6'h00;
         wd_reg    <= 24'h00_0000;
         pd_reg    <= 1'b1;
         for (int i = 0; i < psr_pkg::REG_COUNT; i++)
         begin
            mem_reg[i] <= psr_pkg::REG_RESET;
         end
      end
      else
      begin
         tseen_reg <= tseen_next;
         stb_reg   <= stb_next;
         wa_reg    <= wa_next;
         wd_reg    <= wd_next;
         pd_reg    <= pd_next;
         for (int i = 0; i < psr_pkg::REG_COUNT; i++)
         begin
            mem_reg[i] <= mem_next[i];
         end
      end
   end

   assign o_wr_stb       = stb_reg;
   assign o_wr_addr      = wa_reg;
   assign o_wr_data      = wd_reg;
   assign o_i2c_mode     = mode_reg;
   assign o_i2c_addr_lsb = a0_reg;
   assign o_cs_pulldown  = pd_reg;

   // ==========================================================
   // Checks
   sequence s_commit;
      $changed(tog_lvl) ##1 1'b1;
   endsequence

   a_strobe_follows: assert property (@(posedge i_clk) disable iff
      (!i_arst_n) $changed(tog_lvl) |=> stb_reg)          // R9
      else $error("Commit toggle did not raise strobe");
   a_strobe_single: assert property (@(posedge i_clk) disable iff
      (!i_arst_n) stb_reg |=> !stb_reg)                   // R9
      else $error("Strobe longer than one cycle");
   a_strobe_cause: assert property (@(posedge i_clk) disable iff
      (!i_arst_n) $rose(stb_reg) |-> $past(tog_lvl != tseen_reg)) // R12
      else $error("Strobe without commit");
   a_mode_once: assert property (@(posedge i_clk) disable iff
      (!i_arst_n) done_reg |=> $stable(mode_reg))         // R1
      else $error("Mode changed after latch");
   a_pulldown_mode: assert property (@(posedge i_clk) disable iff
      (!i_arst_n) s_commit |-> pd_reg == !mode_reg)       // R2
      else $error("Pull-down wrong for mode");
   a_wr_target: assert property (@(posedge i_clk) disable iff
      (!i_arst_n) stb_reg && wa_reg != psr_pkg::RO_ADDR
      && wa_reg != psr_pkg::COR_ADDR && wa_reg != psr_pkg::W1C_ADDR
      |-> mem_reg[wa_reg] == wd_reg)                      // R9
      else $error("Write not stored");
   a_ro_fixed: assert property (@(posedge i_clk) disable iff
      (!i_arst_n) ##1 mem_reg[psr_pkg::RO_ADDR] == psr_pkg::RO_VALUE) // R15
      else $error("Read-only word changed");
   a_lsb_spi: assert property (@(posedge i_clk) disable iff
      (!i_arst_n) mode_reg == psr_pkg::MODE_SPI ##1
      mode_reg == psr_pkg::MODE_SPI |-> $stable(a0_reg))  // R18
      else $error("Address bit moved in serial mode");
endmodule

/* File: bench/psr_host_model.sv */
// Behavioural serial host that frames transfers on its own link clock
module psr_host_model
(
   // Link pins
   output logic      o_sclk,
   output logic      o_cs,
   output logic      o_mosi,
   input  wire logic i_miso
);
   timeunit 1ns;
   timeprecision 100ps;
   logic hdr_miso; // Any high seen on the output during the header

   // ==========================================
   // Idle pins; the link clock stands still between frames
   initial
   begin
      o_sclk = 1'b0;
      o_cs = 1'b0;
      o_mosi = 1'b0;
      hdr_miso = 1'b0;
   end

   // Holds select and serial input at fixed levels outside frames
   task automatic park(input logic cs_lvl, input logic mosi_lvl);
      o_cs = cs_lvl;
      o_mosi = mosi_lvl;
   endtask

   // One frame of the given clock count; fewer than 32 aborts it
   task automatic frame(input logic wr, input logic [5:0] addr,
                        input logic [23:0] data, input int clocks,
                        output logic [23:0] rd);
      logic [31:0] word;
      word = {wr, addr, 1'b0, data};
      rd = 24'h00_0000;
      hdr_miso = 1'b0;
      o_cs = 1'b1;
      #8;
      for (int k = 0; k < clocks; k++)
      begin
         o_mosi = word[31 - k];
         #6;
         if (k >= 8)
            rd = {rd[22:0], i_miso};
         else
            hdr_miso = hdr_miso | i_miso;
         o_sclk = 1'b1;
         #6;
         o_sclk = 1'b0;
      end
      #8;
      o_cs = 1'b0;
      // A released line must not keep showing its last value
      o_mosi = ~o_mosi;
   endtask
endmodule

/* File: bench/test_pmic_spi_register_port.sv */
// Self-checking bench for the serial register port
module test_pmic_spi_register_port;
   timeunit 1ns;
   timeprecision 100ps;

   // ==========================================
   // Signals
   logic        i_clk, i_arst_n, i_cold_start;
   logic [23:0] i_hw_status, i_hw_set, wr_data, rd;
   logic        sclk, cs, mosi, miso, oe_n, pd, i2c, lsb, stb;
   logic [5:0]  wr_addr;
   int          fail_count, compares, stb_seen;

   psr_port DUT (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_sclk(sclk),
      .i_cs(cs), .i_mosi(mosi), .o_miso(miso), .o_miso_oe_n(oe_n),
      .o_cs_pulldown(pd), .i_cold_start(i_cold_start),
      .o_i2c_mode(i2c), .o_i2c_addr_lsb(lsb), .o_wr_stb(stb),
      .o_wr_addr(wr_addr), .o_wr_data(wr_data),
      .i_hw_status(i_hw_status), .i_hw_set(i_hw_set));

   psr_host_model host (.o_sclk(sclk), .o_cs(cs), .o_mosi(mosi),
      .i_miso(miso));

   // ==========================================
   // Clock, defaults and watchdog
   initial
   begin
      i_clk = 1'b0;
      forever #25 i_clk = ~i_clk;
   end

   initial
   begin
      i_arst_n = 1'b0;
      i_cold_start = 1'b0;
      i_hw_status = 24'h3C_A5F0;
      i_hw_set = 24'h00_0000;
      #500000;
      fail_count++;
      close_out();
   end

   // Strobe pulses counted in the system domain
   always @(negedge i_clk)
      if (stb === 1'b1)
         stb_seen++;

   // Output driven only while selected in serial mode
   always @(negedge i_clk)
   begin
      #1;
      if (i_arst_n === 1'b1)
         chk({23'h0, oe_n}, {23'h0, !(cs && !i2c)}, "oe_n");
   end

   // ==========================================
   // Shared tasks
   task automatic chk(input logic [23:0] got, input logic [23:0] exp,
                      input string what);
      compares++;
      if (got !== exp)
      begin
         fail_count++;
         $display("unexpected at %0t: %s got %h want %h",
                  $time, what, got, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge i_clk);
      #2;
   endtask

   task automatic close_out;
      if (fail_count == 0 && compares > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // Reset with select and serial input parked for the cold start
   task automatic do_reset(input logic cs_lvl, input logic mosi_lvl);
      cyc(1);
      host.park(cs_lvl, mosi_lvl);
      i_cold_start = 1'b0;
      i_arst_n = 1'b0;
      cyc(20);
      i_arst_n = 1'b1;
      cyc(6);
      i_cold_start = 1'b1;
      cyc(8);
   endtask

   // One frame, then the strobe count; a negative count skips it
   task automatic xfer(input logic wr, input logic [5:0] a,
                       input logic [23:0] d, input int clocks,
                       input int want);
      int base;
      base = stb_seen;
      host.frame(wr, a, d, clocks, rd);
      chk({23'h0, host.hdr_miso}, 24'h00_0000, "header zero");
      cyc(12);
      if (want >= 0)
         chk(24'(stb_seen - base), 24'(want), "strobes");
   endtask

   // ==========================================
   // Scenarios
   task automatic mode_i2c;
      do_reset(1'b1, 1'b1);
      chk({23'h0, i2c}, 24'h00_0001, "i2c mode");
      chk({23'h0, pd}, 24'h00_0000, "pulldown off");
      chk({23'h0, lsb}, 24'h00_0001, "lsb high");
      host.park(1'b0, 1'b0);
      cyc(10);
      chk({23'h0, i2c}, 24'h00_0001, "mode kept");
      chk({23'h0, lsb}, 24'h00_0000, "lsb low");
   endtask

   task automatic mode_spi;
      do_reset(1'b0, 1'b1);
      chk({23'h0, i2c}, 24'h00_0000, "spi mode");
      chk({23'h0, pd}, 24'h00_0001, "pulldown on");
      chk({23'h0, lsb}, 24'h00_0000, "lsb unused");
   endtask

   task automatic write_read;
      xfer(1'b1, 6'h05, 24'hA5_5A3C, 32, 1);
      chk(rd, 24'h00_0000, "old zero");
      xfer(1'b1, 6'h05, 24'h12_3456, 32, 1);
      chk(rd, 24'hA5_5A3C, "old value");
      chk({18'h0, wr_addr}, 24'h00_0005, "wr addr");
      chk(wr_data, 24'h12_3456, "wr data");
      xfer(1'b0, 6'h05, 24'hFF_FFFF, 32, 0);
      chk(rd, 24'h12_3456, "read");
      xfer(1'b0, 6'h05, 24'h00_0000, 32, 0);
      chk(rd, 24'h12_3456, "unchanged");
      xfer(1'b1, 6'h3F, 24'h80_0001, 32, 1);
      xfer(1'b0, 6'h3F, 24'h00_0000, 32, 0);
      chk(rd, 24'h80_0001, "top index");
   endtask

   task automatic abort;
      xfer(1'b1, 6'h05, 24'h00_0F00, 31, 0);
      xfer(1'b0, 6'h05, 24'h00_0000, 32, 0);
      chk(rd, 24'h12_3456, "aborted");
   endtask

   task automatic special;
      i_hw_set = 24'h00_0011;
      cyc(1);
      i_hw_set = 24'h00_0000;
      cyc(4);
      xfer(1'b0, 6'h00, 24'h00_0000, 32, 0);
      chk(rd, 24'h00_0011, "sticky");
      xfer(1'b1, 6'h00, 24'h00_0001, 32, -1);
      xfer(1'b0, 6'h00, 24'h00_0000, 32, 0);
      chk(rd, 24'h00_0010, "w1c");
      xfer(1'b1, 6'h02, 24'hFF_FFFF, 32, -1);
      xfer(1'b0, 6'h02, 24'h00_0000, 32, 0);
      chk(rd, 24'h3C_A5F0, "status");
      xfer(1'b1, 6'h07, 24'hFF_FFFF, 32, -1);
      xfer(1'b0, 6'h07, 24'h00_0000, 32, 0);
      chk(rd, 24'h00_0000, "read only");
   endtask

   // ==========================================
   // Main sequence
   initial
   begin
      fail_count = 0;
      compares = 0;
      stb_seen = 0;
      mode_i2c();
      mode_spi();
      write_read();
      abort();
      special();
      close_out();
   end
endmodule
